// [hw/ppd_consts.vh]
`ifndef PPD_CONSTS_VH
`define PPD_CONSTS_VH
// Register word addresses
`define PPD_ADDR_CFG 8'h00
`define PPD_ADDR_NOMV 8'h01
`define PPD_ADDR_NLVL 8'h02
// Per-phase block offsets, phase p at 8'h10 * (p + 1)
`define PPD_OFF_GAIN 4'h0
`define PPD_OFF_VAROS 4'h1
`define PPD_OFF_FVAROS 4'h2
`define PPD_OFF_WOS 4'h3
`define PPD_OFF_VAR 4'h4
`define PPD_OFF_VA 4'h5
`define PPD_OFF_FVAR 4'h6
`define PPD_OFF_PF 4'h7
`define PPD_OFF_WATT 4'h8
`define PPD_OFF_EGY_LO 4'h9
`define PPD_OFF_EGY_HI 4'ha
`define PPD_OFF_PSUM 4'hb
// General config bit positions
`define PPD_CFG_W 12
`define PPD_CFG_RST 12'h000
`define PPD_CFG_RUN 0
`define PPD_CFG_VARDIS 1
`define PPD_CFG_FSEL 2
`define PPD_CFG_RBYP 3
`define PPD_CFG_ABYP 4
`define PPD_CFG_ACCEN 5
`define PPD_CFG_RELOAD 6
`define PPD_CFG_MODE_LSB 7
`define PPD_CFG_NOMEN_LSB 9
// Active accumulation modes
`define PPD_MODE_SIGNED 2'b00
`define PPD_MODE_ABS 2'b01
`define PPD_MODE_POS 2'b10
`define PPD_MODE_NEG 2'b11
// Scaling slices and filter
`define PPD_PROD_MSB 47
`define PPD_PROD_LSB 16
`define PPD_GAIN_MSB 54
`define PPD_GAIN_LSB 23
`define PPD_VA_MSB 58
`define PPD_VA_LSB 27
`define PPD_LPF_SHIFT 6
// Power factor window and format
`define PPD_PF_WINDOW_MS 1024
`define PPD_DSP_RATE_HZ 4000
`define PPD_PF_ONE 32'h07ffffff
`define PPD_PF_MINUS_ONE 32'hf8000000
`define PPD_DIV_STEPS 5'h1b
// Nominal line frequencies
`define PPD_FREQ_50 7'h32
`define PPD_FREQ_60 7'h3c
`endif

// [hw/ppd_datapath.v]
// Contract
// - Multiply 90-degree shifted current by voltage
// - Reactive low-pass unless bypass bit set
// - Reactive gets power gain then offset
// - Results update at each 4 kSPS sample
// - Three identical phases, own coefficients
// - Reactive offset scaled like reactive result
// - Reactive disable stops total reactive power
// - Apparent is current rms times voltage rms, gained
// - Nominal voltage replaces voltage rms when enabled
// - Frequency select: clear 50 Hz, set 60
// - Fundamental tracking within 5 Hz of nominal
// - Fundamental reactive: gain then fundamental offset
// - Fundamental offset scaled like fundamental result
// - Power factor is active sum over apparent sum
// - Power factor sign follows active power
// - Power factor in 5.27 signed format
// - No-load and sign decide energy accumulation
// - Energy ready adds or latches user energy
// - Power sum unconditional, latched at power ready
// - Accumulators run only with accumulate enable
// - Active low-pass unless bypass bit set
// - Mode: signed, absolute, positive, negative
// - No-load phase accumulates zero energy
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "ppd_consts.vh"
module ppd_datapath (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Sample streams, three phases packed, phase A lowest
  input wire sample_stb_i,
  input wire [71:0] cur_wave_i,
  input wire [71:0] cur_quad_i,
  input wire [71:0] volt_wave_i,
  input wire [71:0] fund_cur_quad_i,
  input wire [71:0] fund_volt_i,
  input wire [95:0] cur_rms_i,
  input wire [95:0] volt_rms_i,
  // Accumulation timing and no-load status
  input wire [2:0] noload_i,
  input wire energy_ready_i,
  input wire power_ready_i,
  // Outputs to the tracking front end
  output wire run_o,
  output wire line_freq_select_o,
  output wire [6:0] nominal_freq_o,
  output wire [31:0] nominal_level_o,
  output wire results_valid_o
);

  localparam [31:0] PF_LAST = (`PPD_PF_WINDOW_MS * `PPD_DSP_RATE_HZ) / 1000 - 1;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DIV = 2'b10;

  // Phase block hit, shared by write and read decode
  function ph_hit;
    input [7:0] a;
    input integer p;
    begin
      ph_hit = ({28'h0000000, a[7:4]} == p + 1);
    end
  endfunction

  // Gain correction: x * (1 + g / 2^23)
  function signed [31:0] gain_apply;
    input signed [31:0] x;
    input signed [31:0] g;
    reg signed [63:0] pr;
    begin
      pr = x * g;
      gain_apply = x + pr[`PPD_GAIN_MSB:`PPD_GAIN_LSB];
    end
  endfunction

  // Sample chosen for energy by mode and no-load
  function signed [31:0] acc_sel;
    input signed [31:0] w;
    input [1:0] mode;
    input nl;
    begin
      acc_sel = 32'h00000000;
      if (!nl) begin
        case (mode)
          `PPD_MODE_SIGNED: acc_sel = w;
          `PPD_MODE_ABS: acc_sel = w[31] ? -w : w;
          `PPD_MODE_POS: acc_sel = w[31] ? 32'h00000000 : w;
          `PPD_MODE_NEG: acc_sel = w[31] ? w : 32'h00000000;
          default: acc_sel = 32'h00000000;
        endcase
      end
    end
  endfunction

  reg [`PPD_CFG_W-1:0] cfg_reg;
  reg [31:0] nomv_reg;
  reg [31:0] nlvl_reg;
  reg stb_d_reg;
  reg [11:0] pf_cnt_reg;
  reg [31:0] rd_next;
  wire [31:0] ph_rd [0:2];
  wire run = cfg_reg[`PPD_CFG_RUN];
  wire acc_en = cfg_reg[`PPD_CFG_ACCEN];
  wire [1:0] mode = cfg_reg[`PPD_CFG_MODE_LSB +: 2];
  wire pf_end = stb_d_reg && (pf_cnt_reg == PF_LAST[11:0]);

  assign run_o = run;
  assign line_freq_select_o = cfg_reg[`PPD_CFG_FSEL];
  // Tracking band is centred here; wider swings need software
  assign nominal_freq_o = cfg_reg[`PPD_CFG_FSEL] ? `PPD_FREQ_60 : `PPD_FREQ_50;
  assign nominal_level_o = nlvl_reg;
  assign results_valid_o = stb_d_reg;

  // Shared registers; reactive-disable and frequency-select bits are only safe to change with run low
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= `PPD_CFG_RST;
      nomv_reg <= 32'h00000000;
      nlvl_reg <= 32'h00000000;
    end else if (wr_i) begin
      if (addr_i == `PPD_ADDR_CFG)
        cfg_reg <= wdata_i[`PPD_CFG_W-1:0];
      if (addr_i == `PPD_ADDR_NOMV)
        nomv_reg <= wdata_i;
      if (addr_i == `PPD_ADDR_NLVL)
        nlvl_reg <= wdata_i;
    end
  end

  // Sample pacing and power factor window counter
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stb_d_reg <= 1'b0;
      pf_cnt_reg <= 12'h000;
    end else begin
      stb_d_reg <= sample_stb_i && run;
      if (!run)
        pf_cnt_reg <= 12'h000;
      else if (stb_d_reg)
        pf_cnt_reg <= pf_end ? 12'h000 : pf_cnt_reg + 12'h001;
    end
  end

  // Read mux; unmapped words read zero
  always @* begin
    rd_next = 32'h00000000;
    case (addr_i)
      `PPD_ADDR_CFG: rd_next = {{(32-`PPD_CFG_W){1'b0}}, cfg_reg};
      `PPD_ADDR_NOMV: rd_next = nomv_reg;
      `PPD_ADDR_NLVL: rd_next = nlvl_reg;
      default: rd_next = ph_rd[0] | ph_rd[1] | ph_rd[2];
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      rdata_o <= 32'h00000000;
    else
      rdata_o <= rd_i ? rd_next : 32'h00000000;
  end

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_ph
      wire hit = ph_hit(addr_i, p);
      reg signed [31:0] gain_reg;
      reg signed [31:0] var_os_reg;
      reg signed [31:0] fvar_os_reg;
      reg signed [31:0] w_os_reg;
      reg signed [31:0] w_lpf_reg;
      reg signed [31:0] q_lpf_reg;
      reg signed [31:0] watt_reg;
      reg signed [31:0] var_reg;
      reg signed [31:0] fvar_reg;
      reg signed [31:0] va_reg;
      reg signed [41:0] egy_acc_reg;
      reg signed [63:0] egy_user_reg;
      reg signed [41:0] pwr_acc_reg;
      reg signed [41:0] psum_reg;
      reg signed [43:0] wsum_reg;
      reg signed [43:0] vasum_reg;
      reg [1:0] st_reg;
      reg [45:0] rem_reg;
      reg [43:0] den_reg;
      reg [26:0] q_reg;
      reg [4:0] cnt_reg;
      reg neg_reg;
      reg signed [31:0] pf_reg;
      reg [31:0] rd_v;

      // Offsets share the result scaling, so codes add directly; gain scales by 2^23
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          gain_reg <= 32'h00000000;
          var_os_reg <= 32'h00000000;
          fvar_os_reg <= 32'h00000000;
          w_os_reg <= 32'h00000000;
        end else if (wr_i && hit) begin
          case (addr_i[3:0])
            `PPD_OFF_GAIN: gain_reg <= wdata_i;
            `PPD_OFF_VAROS: var_os_reg <= wdata_i;
            `PPD_OFF_FVAROS: fvar_os_reg <= wdata_i;
            `PPD_OFF_WOS: w_os_reg <= wdata_i;
            default: ;
          endcase
        end
      end

      // Instantaneous products
      wire signed [23:0] iw = cur_wave_i[p*24 +: 24];
      wire signed [23:0] iq = cur_quad_i[p*24 +: 24];
      wire signed [23:0] vw = volt_wave_i[p*24 +: 24];
      wire signed [23:0] fiq = fund_cur_quad_i[p*24 +: 24];
      wire signed [23:0] fv = fund_volt_i[p*24 +: 24];
      wire signed [47:0] pw = iw * vw;
      wire signed [47:0] pq = iq * vw;
      wire signed [47:0] pf48 = fiq * fv;
      wire signed [31:0] w_inst = pw[`PPD_PROD_MSB:`PPD_PROD_LSB];
      wire signed [31:0] q_inst = pq[`PPD_PROD_MSB:`PPD_PROD_LSB];
      wire signed [31:0] f_inst = pf48[`PPD_PROD_MSB:`PPD_PROD_LSB];

      // Apparent: substitute nominal voltage on tamper
      wire nom_en = cfg_reg[`PPD_CFG_NOMEN_LSB + p];
      wire [31:0] v_use = nom_en ? nomv_reg : volt_rms_i[p*32 +: 32];
      wire [63:0] va64 = cur_rms_i[p*32 +: 32] * v_use;
      wire signed [31:0] va_raw = va64[`PPD_VA_MSB:`PPD_VA_LSB];

      // First-order low-pass, one extra bit against overflow
      wire signed [32:0] w_dif = {w_inst[31], w_inst} - {w_lpf_reg[31], w_lpf_reg};
      wire signed [32:0] q_dif = {q_inst[31], q_inst} - {q_lpf_reg[31], q_lpf_reg};
      wire signed [32:0] w_stp = w_dif >>> `PPD_LPF_SHIFT;
      wire signed [32:0] q_stp = q_dif >>> `PPD_LPF_SHIFT;
      wire signed [31:0] w_sel = cfg_reg[`PPD_CFG_ABYP] ? w_inst : w_lpf_reg;
      wire signed [31:0] q_sel = cfg_reg[`PPD_CFG_RBYP] ? q_inst : q_lpf_reg;

      // Results register once per sample while running
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          w_lpf_reg <= 32'h00000000;
          q_lpf_reg <= 32'h00000000;
          watt_reg <= 32'h00000000;
          var_reg <= 32'h00000000;
          fvar_reg <= 32'h00000000;
          va_reg <= 32'h00000000;
        end else if (sample_stb_i && run) begin
          w_lpf_reg <= w_lpf_reg + w_stp[31:0];
          q_lpf_reg <= q_lpf_reg + q_stp[31:0];
          watt_reg <= gain_apply(w_sel, gain_reg) + w_os_reg;
          if (cfg_reg[`PPD_CFG_VARDIS])
            var_reg <= 32'h00000000;
          else
            var_reg <= gain_apply(q_sel, gain_reg) + var_os_reg;
          fvar_reg <= gain_apply(f_inst, gain_reg) + fvar_os_reg;
          va_reg <= gain_apply(va_raw, gain_reg);
        end
      end

      // Energy and power accumulation on the settled result
      wire signed [31:0] e_smp = acc_sel(watt_reg, mode, noload_i[p]);
      wire signed [41:0] e_add = stb_d_reg ? {{10{e_smp[31]}}, e_smp} : 42'h00000000000;
      wire signed [41:0] p_add = stb_d_reg ? {{10{watt_reg[31]}}, watt_reg} : 42'h00000000000;
      wire signed [41:0] e_sum = egy_acc_reg + e_add;
      wire signed [41:0] p_sum = pwr_acc_reg + p_add;
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          egy_acc_reg <= 42'h00000000000;
          egy_user_reg <= 64'h0000000000000000;
          pwr_acc_reg <= 42'h00000000000;
          psum_reg <= 42'h00000000000;
        end else if (acc_en) begin
          if (energy_ready_i) begin
            egy_acc_reg <= 42'h00000000000;
            if (cfg_reg[`PPD_CFG_RELOAD])
              egy_user_reg <= {{22{e_sum[41]}}, e_sum};
            else
              egy_user_reg <= egy_user_reg + {{22{e_sum[41]}}, e_sum};
          end else begin
            egy_acc_reg <= e_sum;
          end
          if (power_ready_i) begin
            pwr_acc_reg <= 42'h00000000000;
            psum_reg <= p_sum;
          end else begin
            pwr_acc_reg <= p_sum;
          end
        end
      end

      // Window sums feeding the power factor divider
      wire signed [43:0] ws_n = wsum_reg + {{12{watt_reg[31]}}, watt_reg};
      wire signed [43:0] vs_n = vasum_reg + {{12{va_reg[31]}}, va_reg};
      wire [43:0] ws_abs = ws_n[43] ? -ws_n : ws_n;
      wire [43:0] vs_abs = vs_n[43] ? -vs_n : vs_n;
      wire [45:0] den_x = {2'b00, den_reg};
      wire rem_ge = (rem_reg >= den_x);
      wire [45:0] rem_sub = rem_ge ? rem_reg - den_x : rem_reg;
      wire signed [31:0] pf_mag = {5'b00000, q_reg[25:0], rem_ge};

      // Serial divide, 27 fraction bits, saturates at unity
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          wsum_reg <= 44'h00000000000;
          vasum_reg <= 44'h00000000000;
          st_reg <= ST_IDLE;
          rem_reg <= 46'h000000000000;
          den_reg <= 44'h00000000000;
          q_reg <= 27'h0000000;
          cnt_reg <= 5'h00;
          neg_reg <= 1'b0;
          pf_reg <= 32'h00000000;
        end else begin
          if (!run) begin
            wsum_reg <= 44'h00000000000;
            vasum_reg <= 44'h00000000000;
          end else if (stb_d_reg) begin
            wsum_reg <= pf_end ? 44'h00000000000 : ws_n;
            vasum_reg <= pf_end ? 44'h00000000000 : vs_n;
          end
          case (st_reg)
            ST_IDLE: begin
              if (pf_end) begin
                neg_reg <= ws_n[43];
                den_reg <= vs_abs;
                rem_reg <= {1'b0, ws_abs, 1'b0};
                q_reg <= 27'h0000000;
                cnt_reg <= 5'h00;
                if (vs_abs == 44'h00000000000)
                  pf_reg <= 32'h00000000;
                else if (ws_abs >= vs_abs)
                  pf_reg <= ws_n[43] ? `PPD_PF_MINUS_ONE : `PPD_PF_ONE;
                else
                  st_reg <= ST_DIV;
              end
            end
            ST_DIV: begin
              rem_reg <= {rem_sub[44:0], 1'b0};
              q_reg <= {q_reg[25:0], rem_ge};
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == `PPD_DIV_STEPS - 5'h01) begin
                // Held until the next window closes
                pf_reg <= neg_reg ? -pf_mag : pf_mag;
                st_reg <= ST_IDLE;
              end
            end
            default: st_reg <= ST_IDLE;
          endcase
        end
      end

      // Phase read view, zero when another block is addressed
      always @* begin
        rd_v = 32'h00000000;
        if (hit) begin
          case (addr_i[3:0])
            `PPD_OFF_GAIN: rd_v = gain_reg;
            `PPD_OFF_VAROS: rd_v = var_os_reg;
            `PPD_OFF_FVAROS: rd_v = fvar_os_reg;
            `PPD_OFF_WOS: rd_v = w_os_reg;
            `PPD_OFF_VAR: rd_v = var_reg;
            `PPD_OFF_VA: rd_v = va_reg;
            `PPD_OFF_FVAR: rd_v = fvar_reg;
            `PPD_OFF_PF: rd_v = pf_reg;
            `PPD_OFF_WATT: rd_v = watt_reg;
            `PPD_OFF_EGY_LO: rd_v = egy_user_reg[31:0];
            `PPD_OFF_EGY_HI: rd_v = egy_user_reg[63:32];
            `PPD_OFF_PSUM: rd_v = psum_reg[41:10]; // Top 32 bits only
            default: rd_v = 32'h00000000;
          endcase
        end
      end
      assign ph_rd[p] = rd_v;
    end
  endgenerate

endmodule // ppd_datapath

// [verification/ppd_datapath_properties.sv]
`timescale 1ns/1ps
module ppd_datapath_properties (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // Stream and timing
  input wire sample_stb_i,
  input wire energy_ready_i,
  // Front end outputs
  input wire run_o,
  input wire line_freq_select_o,
  input wire [6:0] nominal_freq_o,
  input wire [31:0] nominal_level_o,
  input wire results_valid_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Tracking target follows the select bit
  property p_freq_map;
    nominal_freq_o == (line_freq_select_o ? 7'h3c : 7'h32);
  endproperty
  a_freq_map: assert property (p_freq_map)
    else $error("nominal frequency does not follow select");
  property p_cfg_fsel;
    wr_i && addr_i == 8'h00 |=> line_freq_select_o == $past(wdata_i[2]);
  endproperty
  a_cfg_fsel: assert property (p_cfg_fsel)
    else $error("frequency select not loaded");
  property p_cfg_run;
    wr_i && addr_i == 8'h00 |=> run_o == $past(wdata_i[0]);
  endproperty
  a_cfg_run: assert property (p_cfg_run)
    else $error("run bit not loaded");
  property p_fsel_hold;
    !(wr_i && addr_i == 8'h00) |=> $stable(line_freq_select_o);
  endproperty
  a_fsel_hold: assert property (p_fsel_hold)
    else $error("frequency select moved without a write");
  property p_lvl_wr;
    wr_i && addr_i == 8'h02 |=> nominal_level_o == $past(wdata_i);
  endproperty
  a_lvl_wr: assert property (p_lvl_wr)
    else $error("nominal level not loaded");
  property p_lvl_rd;
    rd_i && addr_i == 8'h02 |=> rdata_o == nominal_level_o;
  endproperty
  a_lvl_rd: assert property (p_lvl_rd)
    else $error("nominal level readback differs");
  property p_cfg_rd;
    rd_i && addr_i == 8'h00 |=> rdata_o[0] == run_o && rdata_o[2] == line_freq_select_o;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("config readback differs from outputs");
  property p_valid_after;
    sample_stb_i && run_o |=> results_valid_o;
  endproperty
  a_valid_after: assert property (p_valid_after)
    else $error("taken sample gave no valid pulse");
  property p_valid_cause;
    results_valid_o |-> $past(sample_stb_i && run_o);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("valid pulse without a taken sample");
  // Main scenarios reached
  c_sample: cover property (sample_stb_i && run_o);
  c_pf_read: cover property (rd_i && addr_i == 8'h17);
  c_energy: cover property (energy_ready_i && run_o);
endmodule // ppd_datapath_properties

bind ppd_datapath ppd_datapath_properties i_ppd_datapath_properties (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_stb_i(sample_stb_i),
  .energy_ready_i(energy_ready_i), .run_o(run_o), .line_freq_select_o(line_freq_select_o),
  .nominal_freq_o(nominal_freq_o), .nominal_level_o(nominal_level_o),
  .results_valid_o(results_valid_o));

// [verification/ppd_host_model.sv]
`timescale 1ns/1ps
module ppd_host_model (
  // Clock
  input wire core_clk_i,
  // Register port, master side
  output reg [7:0] addr_o,
  output reg [31:0] wdata_o,
  output reg wr_o,
  output reg rd_o,
  input wire [31:0] rdata_i
);
  reg [11:0] cfg_reg;
  // Idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    cfg_reg = 12'h000;
  end
  // Released lines show the inverse, so stale values never pass
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge core_clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge core_clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge core_clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1 d = rdata_i;
    end
  endtask
  // Reactive-disable and frequency-select bits change only with run stopped
  task cfg(input [11:0] nv);
    begin
      if (nv[2:1] != cfg_reg[2:1]) begin
        if (cfg_reg[0])
          wr(8'h00, {20'h0, cfg_reg[11:1], 1'b0});
        wr(8'h00, {20'h0, nv[11:1], 1'b0});
      end
      wr(8'h00, {20'h0, nv});
      cfg_reg = nv;
    end
  endtask
  // Level is the full-scale ratio times the fixed constant
  task lvl(input [7:0] ratio);
    wr(8'h02, ratio * 32'd1144084);
  endtask
endmodule // ppd_host_model

// [verification/ppd_datapath_test.sv]
`timescale 1ns/1ps
module ppd_datapath_test;
  reg core_clk;
  reg rst_n;
  reg stb;
  reg ery;
  reg pry;
  reg [2:0] noload;
  reg [71:0] cur;
  reg [71:0] cquad;
  reg [95:0] irms;
  reg [71:0] volt;
  reg [71:0] fvolt;
  reg [95:0] vrms;
  reg [31:0] v;
  reg [39:0] rows [0:7];
  reg [66:0] erow [0:4];
  wire [7:0] addr;
  wire [31:0] wdata;
  wire [31:0] rdata;
  wire wr;
  wire rd;
  wire run;
  wire fsel;
  wire rvalid;
  wire [6:0] nfreq;
  wire [31:0] nlvl;
  integer n_mismatch;
  integer n_checks;
  integer i;
  integer k;
  ppd_datapath i_ppd_datapath (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sample_stb_i(stb), .cur_wave_i(cur),
    .cur_quad_i(cquad), .volt_wave_i(volt), .fund_cur_quad_i(cur), .fund_volt_i(fvolt),
    .cur_rms_i(irms), .volt_rms_i(vrms), .noload_i(noload),
    .energy_ready_i(ery), .power_ready_i(pry), .run_o(run), .line_freq_select_o(fsel),
    .nominal_freq_o(nfreq), .nominal_level_o(nlvl), .results_valid_o(rvalid));
  ppd_host_model i_ppd_host_model (
    .core_clk_i(core_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
  task chk(input [7:0] id, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH reg %h exp %h seen %h", id, exp, seen);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      i_ppd_host_model.rd(a, v);
      chk(a, v, exp);
    end
  endtask
  // Samples spaced well beyond the two-cycle minimum
  task smp(input integer n);
    for (k = 0; k < n; k = k + 1) begin
      @(posedge core_clk);
      stb <= 1'b1;
      @(posedge core_clk);
      stb <= 1'b0;
      #1 chk(8'hf3, {31'h0, rvalid}, 32'h1);
      repeat (3) @(posedge core_clk);
    end
  endtask
  // Ready pulses kept clear of valid cycles
  task pulse;
    begin
      @(posedge core_clk);
      ery <= 1'b1;
      pry <= 1'b1;
      @(posedge core_clk);
      ery <= 1'b0;
      pry <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst_n = 1'b0;
    stb = 1'b0;
    ery = 1'b0;
    pry = 1'b0;
    noload = 3'h0;
    cur = {3{24'h010000}};
    volt = {24'h003000, 24'hfff000, 24'h001000};
    fvolt = {24'h000400, 24'h000300, 24'h000200};
    vrms = {3{32'h00002000}};
    irms = {3{32'h08000000}};
    cquad = {3{24'h008000}};
    rows[0] = {8'h14, 32'h00000805};
    rows[1] = {8'h24, 32'hfffff000};
    rows[2] = {8'h15, 32'h00002000};
    rows[3] = {8'h25, 32'h00004000};
    rows[4] = {8'h16, 32'h00000207};
    rows[5] = {8'h26, 32'h00000600};
    rows[6] = {8'h18, 32'h00001000};
    rows[7] = {8'h38, 32'h00003000};
    erow[0] = {2'b00, 1'b1, 32'h00020000, 32'hfffe0000};
    erow[1] = {2'b01, 1'b1, 32'h00020000, 32'h00020000};
    erow[2] = {2'b10, 1'b1, 32'h00020000, 32'h00000000};
    erow[3] = {2'b11, 1'b1, 32'h00000000, 32'hfffe0000};
    erow[4] = {2'b00, 1'b0, 32'h00020000, 32'hfffc0000};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(8'h00, 32'h0);
    rdchk(8'h17, 32'h0);
    rdchk(8'hff, 32'h0);
    chk(8'hf0, {25'h0, nfreq}, 32'h32);
    i_ppd_host_model.lvl(8'd2);
    #1 chk(8'hf1, nlvl, 32'd2288168);
    rdchk(8'h02, 32'd2288168);
    $display("reset and setup test done");
    i_ppd_host_model.wr(8'h01, 32'h3000);
    i_ppd_host_model.wr(8'h11, 32'h5);
    i_ppd_host_model.wr(8'h12, 32'h7);
    i_ppd_host_model.wr(8'h20, 32'h00800000);
    i_ppd_host_model.cfg(12'h01d);
    #1 chk(8'hf0, {25'h0, nfreq}, 32'h3c);
    chk(8'hf2, {30'h0, fsel, run}, 32'h3);
    i_ppd_host_model.cfg(12'h019);
    #1 chk(8'hf0, {25'h0, nfreq}, 32'h32);
    smp(1);
    for (i = 0; i < 8; i = i + 1)
      rdchk(rows[i][39:32], rows[i][31:0]);
    $display("datapath rows test done");
    // Filter in, then reactive disable, then nominal voltage
    i_ppd_host_model.cfg(12'h011);
    smp(1);
    rdchk(8'h14, 32'h25);
    i_ppd_host_model.cfg(12'h01b);
    @(posedge core_clk);
    fvolt <= {24'h000400, 24'h000300, 24'h000400};
    smp(1);
    rdchk(8'h14, 32'h0);
    rdchk(8'h16, 32'h407);
    @(posedge core_clk);
    irms <= {3{32'h10000000}};
    vrms <= {3{32'h00001000}};
    i_ppd_host_model.cfg(12'h219);
    smp(1);
    rdchk(8'h15, 32'h6000);
    rdchk(8'h25, 32'h4000);
    rdchk(8'h35, 32'h2000);
    i_ppd_host_model.cfg(12'h019);
    $display("filter disable nominal test done");
    // Fresh window: stop and restart run
    i_ppd_host_model.wr(8'h00, 32'h018);
    i_ppd_host_model.wr(8'h00, 32'h019);
    smp(4095);
    rdchk(8'h17, 32'h0);
    smp(1);
    repeat (40) @(posedge core_clk);
    rdchk(8'h17, 32'h04000000);
    rdchk(8'h27, 32'hfc000000);
    rdchk(8'h37, 32'h07ffffff);
    smp(10);
    rdchk(8'h17, 32'h04000000);
    $display("power factor test done");
    i_ppd_host_model.wr(8'h20, 32'h0);
    @(posedge core_clk);
    volt <= {24'h010000, 24'hff0000, 24'h010000};
    noload <= 3'b100;
    for (i = 0; i < 5; i = i + 1) begin
      i_ppd_host_model.cfg({3'b000, erow[i][66:65], erow[i][64], 6'h31});
      pulse;
      smp(2);
      pulse;
      rdchk(8'h19, erow[i][63:32]);
      rdchk(8'h29, erow[i][31:0]);
      rdchk(8'h39, 32'h0);
      rdchk(8'h1b, 32'h80);
      rdchk(8'h3b, 32'h80);
    end
    i_ppd_host_model.cfg(12'h011);
    pulse;
    smp(2);
    pulse;
    rdchk(8'h29, 32'hfffc0000);
    rdchk(8'h2a, 32'hffffffff);
    $display("energy test done");
    finish_test;
  end
endmodule // ppd_datapath_test
